// ==== verilog/cocr_pkg.sv ====
// Purpose: shared constants for the display-path overlay and cursor register bank
// Assumes: 32-bit AXI4-Lite, one register per aligned word, byte address = 4 x index
// Notes:   register indices keep the printed offsets; see cocr_byte_addr
package cocr_pkg;

    localparam int unsigned AXI_ADDR_W = 12;

    // register indices (printed offsets)
    localparam logic [7:0] IDX_MODE   = 8'h80;
    localparam logic [7:0] IDX_START  = 8'h81;
    localparam logic [7:0] IDX_XL     = 8'h82;
    localparam logic [7:0] IDX_XH     = 8'h83;
    localparam logic [7:0] IDX_YL     = 8'h84;
    localparam logic [7:0] IDX_YH     = 8'h85;
    localparam logic [7:0] IDX_STATUS = 8'h8F;

    // writable bits; all others read as zero
    localparam logic [7:0] MASK_MODE  = 8'h03;
    localparam logic [7:0] MASK_HIGH  = 8'h83;

    localparam int unsigned SIGN_BIT  = 7;
    localparam int unsigned COORD_W   = 10;

    // overlay mode field encoding
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_CURSOR = 2'h1;
    localparam logic [1:0] MODE_INK    = 2'h2;
    localparam logic [1:0] MODE_RSVD   = 2'h3;

    // start code translation: code 0 and step per nonzero code, in bytes
    localparam logic [31:0] START_ZERO_BYTES = 32'h0000_0400;
    localparam logic [31:0] START_STEP_BYTES = 32'h0000_2000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // status register bit positions
    localparam int unsigned ST_MODE_LSB = 0;
    localparam int unsigned ST_BAD      = 2;
    localparam int unsigned ST_ARMED    = 3;

    function automatic logic [AXI_ADDR_W-1:0] cocr_byte_addr(input logic [7:0] idx);
        cocr_byte_addr = AXI_ADDR_W'({idx, 2'b00});
    endfunction

endpackage

// ==== verilog/cocr_coord.sv ====
// Purpose: turns a sign flag plus 10-bit magnitude into a registered signed coordinate
// Assumes: low byte holds bits 7..0, high byte bits 1..0 hold bits 9..8, bit 7 the sign
// Notes:   output forced to zero when the cursor is not the selected overlay
`timescale 1ns/1ns
module cocr_coord
    import cocr_pkg::*;
(
    input  wire logic                clk_sys, // system clock
    input  wire logic                rstn,    // async reset, active low
    input  wire logic                en,      // cursor mode active
    input  wire logic [7:0]          low,     // active low position byte
    input  wire logic [7:0]          high,    // active high position byte with sign
    output logic signed [COORD_W:0]  coord    // two's complement coordinate
);

    logic [COORD_W-1:0] mag;

    assign mag = {high[1:0], low};

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            coord <= '0;
        end else if (!en) begin
            coord <= '0;
        end else if (high[SIGN_BIT]) begin
            coord <= (COORD_W+1)'(-$signed({1'b0, mag}));
        end else begin
            coord <= $signed({1'b0, mag});
        end
    end

endmodule

// ==== verilog/cocr_regs.sv ====
// Purpose: overlay mode, start address and cursor position registers for one display path
// Assumes: vnd is a level, high during the vertical non-display period, synchronous to clk_sys
// Notes:   shadow copies are written by software; active copies change only at vnd rise
// How it works
// - mode field: 00 off, 01 hardware cursor, 10 ink layer, 11 reserved.
// - start code 0 gives memory minus 1024; n up to 128 gives memory minus n*8192, higher n gives zero.
// - a new start code takes effect at the next vertical non-display period.
// - position bytes apply only after the upper vertical byte is written.
// - the upper vertical byte applies at the next vertical non-display period.
// - each coordinate is 10 bits: low byte plus bits 1..0 of high.
// - bit 7 of each high position byte marks the coordinate negative.
// - position registers matter only while hardware cursor mode is selected.
`timescale 1ns/1ns
module cocr_regs
    import cocr_pkg::*;
#(
    parameter int unsigned     ADDR_W    = 21,          // display memory address width
    parameter logic [ADDR_W-1:0] MEM_BYTES = 21'h10_0000 // display memory size in bytes
)(
    input  wire logic                  clk_sys,       // system clock
    input  wire logic                  rstn,          // async reset, active low
    input  wire logic                  vnd,           // vertical non-display level
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,  // write address
    input  wire logic                  s_axi_awvalid, // write address valid
    output logic                       s_axi_awready, // write address ready
    input  wire logic [31:0]           s_axi_wdata,   // write data
    input  wire logic [3:0]            s_axi_wstrb,   // write strobes
    input  wire logic                  s_axi_wvalid,  // write data valid
    output logic                       s_axi_wready,  // write data ready
    output logic [1:0]                 s_axi_bresp,   // write response
    output logic                       s_axi_bvalid,  // write response valid
    input  wire logic                  s_axi_bready,  // write response ready
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,  // read address
    input  wire logic                  s_axi_arvalid, // read address valid
    output logic                       s_axi_arready, // read address ready
    output logic [31:0]                s_axi_rdata,   // read data
    output logic [1:0]                 s_axi_rresp,   // read response
    output logic                       s_axi_rvalid,  // read data valid
    input  wire logic                  s_axi_rready,  // read data ready
    output logic [1:0]                 ovl_mode,      // active overlay mode
    output logic                       ovl_cursor_en, // hardware cursor selected
    output logic                       ovl_ink_en,    // ink layer selected
    output logic [ADDR_W-1:0]          ovl_start,     // overlay start byte address
    output logic                       ovl_start_bad, // active start code out of range
    output logic signed [COORD_W:0]    cursor_x,      // active horizontal position
    output logic signed [COORD_W:0]    cursor_y       // active vertical position
);

    localparam logic [ADDR_W-1:0] ZERO_BYTES = ADDR_W'(START_ZERO_BYTES);
    localparam logic [ADDR_W-1:0] STEP_BYTES = ADDR_W'(START_STEP_BYTES);
    localparam logic [ADDR_W-1:0] MAX_CODE   = ADDR_W'(MEM_BYTES / STEP_BYTES);

    // shadow (software) copies
    logic [7:0] sh_mode;
    logic [7:0] sh_code;
    logic [7:0] sh_xl;
    logic [7:0] sh_xh;
    logic [7:0] sh_yl;
    logic [7:0] sh_yh;
    // active position copies
    logic [7:0] act_xl;
    logic [7:0] act_xh;
    logic [7:0] act_yl;
    logic [7:0] act_yh;
    logic       pos_arm;
    logic       vnd_d;
    logic       vstart;

    // bus holding registers
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic [7:0]            w_byte;
    logic                  w_lane0;
    logic                  wr_do;
    logic                  wr_hit;
    logic                  wr_en;
    logic [7:0]            next_rdata;
    logic                  rd_hit;

    function automatic logic addr_is(input logic [AXI_ADDR_W-1:0] a, input logic [7:0] idx);
        addr_is = ({a[AXI_ADDR_W-1:2], 2'b00} == cocr_byte_addr(idx));
    endfunction

    // vertical non-display period begins
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            vnd_d <= 1'b0;
        end else begin
            vnd_d <= vnd;
        end
    end

    assign vstart = vnd && !vnd_d;

    // ---------------- AXI4-Lite write channel ----------------
    // address and data are taken in either order; the write commits once both are held
    assign wr_do  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    assign wr_hit = addr_is(aw_addr, IDX_MODE) || addr_is(aw_addr, IDX_START) ||
                    addr_is(aw_addr, IDX_XL)   || addr_is(aw_addr, IDX_XH)    ||
                    addr_is(aw_addr, IDX_YL)   || addr_is(aw_addr, IDX_YH)    ||
                    addr_is(aw_addr, IDX_STATUS);
    // only byte lane 0 carries register bits; other lanes are ignored
    assign wr_en  = wr_do && w_lane0;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_awready <= 1'b1;
            aw_addr       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_wready <= 1'b1;
            w_byte       <= '0;
            w_lane0      <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_byte       <= s_axi_wdata[7:0];
            w_lane0      <= s_axi_wstrb[0];
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // shadow registers; reserved bits are dropped on write so they read as zero
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sh_mode <= '0;
            sh_code <= '0;
            sh_xl   <= '0;
            sh_xh   <= '0;
            sh_yl   <= '0;
            sh_yh   <= '0;
        end else if (wr_en) begin
            if (addr_is(aw_addr, IDX_MODE)) begin
                sh_mode <= w_byte & MASK_MODE;
            end
            if (addr_is(aw_addr, IDX_START)) begin
                sh_code <= w_byte;
            end
            if (addr_is(aw_addr, IDX_XL)) begin
                sh_xl <= w_byte;
            end
            if (addr_is(aw_addr, IDX_XH)) begin
                sh_xh <= w_byte & MASK_HIGH;
            end
            if (addr_is(aw_addr, IDX_YL)) begin
                sh_yl <= w_byte;
            end
            if (addr_is(aw_addr, IDX_YH)) begin
                sh_yh <= w_byte & MASK_HIGH;
            end
        end
    end

    // ---------------- AXI4-Lite read channel ----------------
    always_comb begin
        rd_hit     = 1'b1;
        next_rdata = '0;
        if (addr_is(s_axi_araddr, IDX_MODE)) begin
            next_rdata = sh_mode;
        end else if (addr_is(s_axi_araddr, IDX_START)) begin
            next_rdata = sh_code;
        end else if (addr_is(s_axi_araddr, IDX_XL)) begin
            next_rdata = sh_xl;
        end else if (addr_is(s_axi_araddr, IDX_XH)) begin
            next_rdata = sh_xh;
        end else if (addr_is(s_axi_araddr, IDX_YL)) begin
            next_rdata = sh_yl;
        end else if (addr_is(s_axi_araddr, IDX_YH)) begin
            next_rdata = sh_yh;
        end else if (addr_is(s_axi_araddr, IDX_STATUS)) begin
            next_rdata[ST_MODE_LSB +: 2] = ovl_mode;
            next_rdata[ST_BAD]           = ovl_start_bad;
            next_rdata[ST_ARMED]         = pos_arm;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, next_rdata};
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    // ---------------- frame-boundary updates ----------------
    // mode and start code are reloaded every period; unchanged shadows reload unchanged
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ovl_mode      <= MODE_OFF;
            ovl_cursor_en <= 1'b0;
            ovl_ink_en    <= 1'b0;
        end else if (vstart) begin
            ovl_mode      <= sh_mode[1:0];
            ovl_cursor_en <= (sh_mode[1:0] == MODE_CURSOR);
            ovl_ink_en    <= (sh_mode[1:0] == MODE_INK);
        end
    end

    // an out-of-range code drives address zero and raises the bad flag
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ovl_start     <= '0;
            ovl_start_bad <= 1'b0;
        end else if (vstart) begin
            if (sh_code == 8'h00) begin
                ovl_start     <= MEM_BYTES - ZERO_BYTES;
                ovl_start_bad <= 1'b0;
            end else if (ADDR_W'(sh_code) > MAX_CODE) begin
                ovl_start     <= '0;
                ovl_start_bad <= 1'b1;
            end else begin
                ovl_start     <= ADDR_W'(MEM_BYTES - ADDR_W'(sh_code) * STEP_BYTES);
                ovl_start_bad <= 1'b0;
            end
        end
    end

    // upper vertical write arms the position set; a new arm wins over the clear
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pos_arm <= 1'b0;
        end else if (wr_en && addr_is(aw_addr, IDX_YH)) begin
            pos_arm <= 1'b1;
        end else if (vstart) begin
            pos_arm <= 1'b0;
        end
    end

    // all four bytes move together so a frame never sees half a position
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            act_xl <= '0;
            act_xh <= '0;
            act_yl <= '0;
            act_yh <= '0;
        end else if (vstart && pos_arm) begin
            act_xl <= sh_xl;
            act_xh <= sh_xh;
            act_yl <= sh_yl;
            act_yh <= sh_yh;
        end
    end

    cocr_coord u_coord_x (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .en      (ovl_cursor_en),
        .low     (act_xl),
        .high    (act_xh),
        .coord   (cursor_x)
    );

    cocr_coord u_coord_y (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .en      (ovl_cursor_en),
        .low     (act_yl),
        .high    (act_yh),
        .coord   (cursor_y)
    );

    // ---------------- checks ----------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence s_arm_write;
        wr_en && addr_is(aw_addr, IDX_YH);
    endsequence

    sequence s_frame_edge;
        vnd && !vnd_d;
    endsequence

    property p_mode_decode;
        ovl_cursor_en == (ovl_mode == MODE_CURSOR) && ovl_ink_en == (ovl_mode == MODE_INK);
    endproperty
    a_mode_decode: assert property (p_mode_decode) else $error("mode decode mismatch");

    property p_start_zero;
        s_frame_edge ##0 (sh_code == 8'h00) |=> ovl_start == MEM_BYTES - ZERO_BYTES;
    endproperty
    a_start_zero: assert property (p_start_zero) else $error("code 0 address wrong");

    property p_start_step;
        s_frame_edge ##0 (sh_code != 8'h00) ##0 (ADDR_W'(sh_code) <= MAX_CODE)
            |=> ovl_start == ADDR_W'(MEM_BYTES - ADDR_W'($past(sh_code)) * STEP_BYTES);
    endproperty
    a_start_step: assert property (p_start_step) else $error("code n address wrong");

    property p_start_waits;
        !vstart |=> $stable(ovl_start) && $stable(ovl_mode);
    endproperty
    a_start_waits: assert property (p_start_waits) else $error("start moved mid-frame");

    property p_pos_unarmed;
        !(vstart && pos_arm) |=> $stable(act_xl) && $stable(act_yl) && $stable(act_xh);
    endproperty
    a_pos_unarmed: assert property (p_pos_unarmed) else $error("position moved unarmed");

    property p_arm_wins;
        s_arm_write ##0 vstart |=> pos_arm;
    endproperty
    a_arm_wins: assert property (p_arm_wins) else $error("arm lost at frame edge");

    property p_pos_apply;
        s_frame_edge ##0 pos_arm |=> act_yh == $past(sh_yh) && act_xl == $past(sh_xl)
            && act_yl == $past(sh_yl) && act_xh == $past(sh_xh);
    endproperty
    a_pos_apply: assert property (p_pos_apply) else $error("armed set not applied");

    property p_sign_x;
        ovl_cursor_en && act_xh[SIGN_BIT] && $stable(act_xh) && $stable(act_xl)
            |=> cursor_x == -$signed({1'b0, $past(act_xh[1:0]), $past(act_xl)});
    endproperty
    a_sign_x: assert property (p_sign_x) else $error("negative x wrong");

    property p_pos_y;
        ovl_cursor_en && !act_yh[SIGN_BIT] |=> cursor_y == $signed({1'b0, $past(act_yh[1:0]),
            $past(act_yl)});
    endproperty
    a_pos_y: assert property (p_pos_y) else $error("positive y wrong");

    property p_cursor_off;
        !ovl_cursor_en |=> cursor_x == 0 && cursor_y == 0;
    endproperty
    a_cursor_off: assert property (p_cursor_off) else $error("position leaks");

    property p_write_resp;
        wr_do |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write response missing");

endmodule

// ==== sim/cocr_regs_test.sv ====
// Purpose: self-checking bench for the overlay mode, start address and cursor registers
// Assumes: AXI4-Lite master driven here; vnd pulses stand in for vertical blanking
// Notes:   default parameters, so 1 MiB memory and start codes up to 128 valid
`timescale 1ns/1ns
module cocr_regs_test
    import cocr_pkg::*;
;
    localparam logic [11:0] A_MODE = {2'b00, IDX_MODE, 2'b00};
    localparam logic [11:0] A_ST   = {2'b00, IDX_START, 2'b00};
    localparam logic [11:0] A_XL   = {2'b00, IDX_XL, 2'b00};
    localparam logic [11:0] A_XH   = {2'b00, IDX_XH, 2'b00};
    localparam logic [11:0] A_YL   = {2'b00, IDX_YL, 2'b00};
    localparam logic [11:0] A_YH   = {2'b00, IDX_YH, 2'b00};
    localparam logic [11:0] A_STAT = {2'b00, IDX_STATUS, 2'b00};

    logic               clk_sys, rstn, vnd;
    logic [11:0]        awaddr, araddr;
    logic               awvalid, awready, wvalid, wready, bvalid, bready;
    logic [31:0]        wdata, rdata;
    logic [3:0]         wstrb;
    logic [1:0]         bresp, rresp, ovl_mode;
    logic               arvalid, arready, rvalid, rready, cur_en, ink_en, st_bad;
    logic [20:0]        ovl_start;
    logic signed [10:0] cx, cy;
    int                 errors, checks_done;

    cocr_regs dut_u (.clk_sys(clk_sys), .rstn(rstn), .vnd(vnd),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .ovl_mode(ovl_mode),
        .ovl_cursor_en(cur_en), .ovl_ink_en(ink_en), .ovl_start(ovl_start),
        .ovl_start_bad(st_bad), .cursor_x(cx), .cursor_y(cy));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic finish_test;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic axi_write(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        int   n;
        logic aw_done, w_done;
        @(posedge clk_sys);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= {24'h000000, d};
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        aw_done = 1'b0;
        w_done  = 1'b0;
        n = 0;
        while (n < 50) begin
            @(posedge clk_sys);
            n++;
            if (aw_done && w_done && bvalid === 1'b1) break;
            if (!aw_done && awready === 1'b1) begin
                aw_done = 1'b1;
                awvalid <= 1'b0;
            end
            if (!w_done && wready === 1'b1) begin
                w_done = 1'b1;
                wvalid <= 1'b0;
            end
        end
        if (n >= 50) begin
            errors++;
            finish_test();
        end
        check({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int   n;
        logic ar_done;
        @(posedge clk_sys);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        ar_done = 1'b0;
        n = 0;
        while (n < 50) begin
            @(posedge clk_sys);
            n++;
            if (ar_done && rvalid === 1'b1) break;
            if (!ar_done && arready === 1'b1) begin
                ar_done = 1'b1;
                arvalid <= 1'b0;
            end
        end
        if (n >= 50) begin
            errors++;
            finish_test();
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic read_check(input logic [11:0] a, input logic [7:0] exp);
        logic [31:0] d;
        logic [1:0]  r;
        axi_read(a, d, r);
        check(d, {24'h000000, exp});
        check({30'h0, r}, {30'h0, RESP_OKAY});
    endtask

    // one blanking interval; cursor outputs settle two edges after its start
    task automatic frame_edge;
        @(posedge clk_sys);
        vnd <= 1'b1;
        repeat (3) @(posedge clk_sys);
        vnd <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic test_reset;
        logic [11:0] addrs [7] = '{A_MODE, A_ST, A_XL, A_XH, A_YL, A_YH, A_STAT};
        foreach (addrs[i]) read_check(addrs[i], 8'h00);
        check({10'h000, cx, cy}, 32'h0);
        check({11'h000, ovl_start}, 32'h0);
        $display("test reset done");
    endtask

    task automatic test_position;
        axi_write(A_MODE, 8'h01, 4'hF, RESP_OKAY);
        axi_write(A_XL, 8'hFF, 4'hF, RESP_OKAY);
        axi_write(A_XH, 8'h7F, 4'hF, RESP_OKAY);
        axi_write(A_YL, 8'h3F, 4'hF, RESP_OKAY);
        read_check(A_XH, 8'h03);
        frame_edge();
        check(32'(cur_en), 32'h1);
        check({21'h0, cx}, 32'h0);
        axi_write(A_YH, 8'hFC, 4'hF, RESP_OKAY);
        read_check(A_STAT, 8'h09);
        check({21'h0, cy}, 32'h0);
        frame_edge();
        check({21'h0, cx}, {21'h0, 11'h3FF});
        check({21'h0, cy}, {21'h0, 11'h7C1});
        read_check(A_STAT, 8'h01);
        axi_write(A_XL, 8'h05, 4'hF, RESP_OKAY);
        frame_edge();
        check({21'h0, cx}, {21'h0, 11'h3FF});
        axi_write(A_XH, 8'h80, 4'hF, RESP_OKAY);
        axi_write(A_YH, 8'h00, 4'hF, RESP_OKAY);
        frame_edge();
        check({21'h0, cx}, {21'h0, 11'h7FB});
        check({21'h0, cy}, {21'h0, 11'h03F});
        $display("test position done");
    endtask

    task automatic test_mode;
        logic [1:0] modes [3] = '{MODE_RSVD, MODE_OFF, MODE_CURSOR};
        axi_write(A_MODE, 8'hFF, 4'hF, RESP_OKAY);
        read_check(A_MODE, 8'h03);
        foreach (modes[i]) begin
            axi_write(A_MODE, {6'h00, modes[i]}, 4'hF, RESP_OKAY);
            frame_edge();
            check({30'h0, ovl_mode}, {30'h0, modes[i]});
            check({30'h0, cur_en, ink_en}, {30'h0, modes[i] == MODE_CURSOR, 1'b0});
            check({21'h0, cx}, {21'h0, (modes[i] == MODE_CURSOR) ? 11'h7FB : 11'h000});
        end
        $display("test mode done");
    endtask

    task automatic test_start;
        logic [7:0]  codes [5] = '{8'd0, 8'd1, 8'd64, 8'd128, 8'd129};
        logic [20:0] addrs [5] = '{21'hFFC00, 21'hFE000, 21'h80000, 21'h00000, 21'h00000};
        foreach (codes[i]) begin
            axi_write(A_ST, codes[i], 4'hF, RESP_OKAY);
            read_check(A_ST, codes[i]);
            if (i > 0) check({11'h0, ovl_start}, {11'h0, addrs[i-1]});
            frame_edge();
            check({11'h0, ovl_start}, {11'h0, addrs[i]});
            check(32'(st_bad), 32'(codes[i] > 8'd128));
        end
        $display("test start done");
    endtask

    task automatic test_refuse;
        logic [31:0] d;
        logic [1:0]  r;
        axi_write(12'h218, 8'h55, 4'hF, RESP_SLVERR);
        axi_read(12'h218, d, r);
        check({30'h0, r}, {30'h0, RESP_SLVERR});
        axi_write(A_ST, 8'h22, 4'h0, RESP_OKAY);
        read_check(A_ST, 8'd129);
        axi_write(A_STAT, 8'hFF, 4'hF, RESP_OKAY);
        read_check(A_STAT, 8'h05);
        axi_write(A_ST, 8'h00, 4'hF, RESP_OKAY);
        $display("test refuse done");
    endtask

    task automatic test_ink;
        logic [11:0] addrs [4] = '{A_XL, A_XH, A_YL, A_YH};
        foreach (addrs[i]) axi_write(addrs[i], 8'h00, 4'hF, RESP_OKAY);
        axi_write(A_MODE, {6'h00, MODE_INK}, 4'hF, RESP_OKAY);
        frame_edge();
        check({29'h0, cur_en, ink_en, st_bad}, 32'h2);
        check({10'h000, cx, cy}, 32'h0);
        check({11'h000, ovl_start}, {11'h000, 21'hFFC00});
        $display("test ink done");
    endtask

    initial begin
        errors = 0;
        checks_done = 0;
        rstn = 1'b0;
        vnd = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = '0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        test_reset();
        test_position();
        test_mode();
        test_start();
        test_refuse();
        test_ink();
        finish_test();
    end
endmodule
